// ==== core/tcc_core.sv ====
// Timer counter, modulo and shared status/control behind an AHB-Lite slave
`timescale 1ns/1ns
`include "tcc_params.svh"
module tcc_core
  import tcc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Timer side
  input wire logic ext_clk_pin,
  input wire logic fixed_clk_in,
  input wire logic bdm_active,
  output logic overflow_irq
);
  tcc_state_s r, next_r;
  logic rst_n_int;
  // Decoded data phase strobes, shared by the checks at the bottom
  logic sc_wr_phase;
  logic sc_rd_phase;
  logic sc_clear_wr;
  logic cnt_wr_phase;
  logic ovf_evt;

  assign rst_n_int = r.rst_sync[1];
  assign hrdata = r.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign overflow_irq = r.irq;
  assign sc_wr_phase = (r.bus.ph == TCC_BUS_DATA) && r.bus.wr &&
                       (r.bus.addr == `TCC_ADDR_SC);
  assign sc_rd_phase = (r.bus.ph == TCC_BUS_DATA) && !r.bus.wr &&
                       (r.bus.addr == `TCC_ADDR_SC);
  assign sc_clear_wr = sc_wr_phase && !hwdata[`TCC_BIT_TOF];
  assign cnt_wr_phase = (r.bus.ph == TCC_BUS_DATA) && r.bus.wr &&
                        ((r.bus.addr == `TCC_ADDR_CNTH) || (r.bus.addr == `TCC_ADDR_CNTL));

  // Whole word access decodes only the low address bits
  function automatic logic is_reg(input logic [11:0] a, input logic [11:0] ref_a);
    is_reg = (a == ref_a);
  endfunction

  always_comb begin
    logic tick;
    logic src_edge;
    logic at_mod;
    logic free_run;
    logic ovf;
    logic wr_sc, wr_cnt, wr_modh, wr_modl, rd_sc, rd_cnt;
    logic [7:0] wd;
    next_r = r;
    tick = 1'b0;
    src_edge = 1'b0;
    ovf = 1'b0;
    wd = hwdata[7:0];
    at_mod = 1'b0;
    free_run = 1'b0;
    wr_sc = 1'b0;
    wr_cnt = 1'b0;
    wr_modh = 1'b0;
    wr_modl = 1'b0;
    rd_sc = 1'b0;
    rd_cnt = 1'b0;
    ovf_evt = 1'b0;
    next_r.rst_sync = {r.rst_sync[0], 1'b1};
    // Pin side sources pass two flops before edge detection [RULE9]
    next_r.ext_sync = {r.ext_sync[0], ext_clk_pin};
    next_r.fix_sync = {r.fix_sync[0], fixed_clk_in};
    next_r.ext_prev = r.ext_sync[1];
    next_r.fix_prev = r.fix_sync[1];
    // Source selection ahead of the prescaler [RULE8] [RULE11]
    case (r.clks)
      `TCC_CLK_BUS: src_edge = 1'b1;
      `TCC_CLK_FIX: src_edge = r.fix_sync[1] & ~r.fix_prev;
      `TCC_CLK_EXT: src_edge = r.ext_sync[1] & ~r.ext_prev;
      default: src_edge = 1'b0;
    endcase
    if (src_edge && !bdm_active) begin
      next_r.pre_cnt = 7'(r.pre_cnt + 7'h1);
      // Divide by 2**ps: tick when the low ps bits were all ones [RULE10]
      tick = ((r.pre_cnt & 7'((8'h1 << r.ps) - 8'h1)) == 7'((8'h1 << r.ps) - 8'h1));
    end
    free_run = (r.mod == `TCC_ZERO16) || (r.mod == `TCC_ALL16); // [RULE21] [RULE20]
    at_mod = free_run ? (r.cnt == `TCC_ALL16) : (r.cnt == r.mod);
    // Counter frozen in debug since tick needs bdm_active low [RULE17]
    if (tick) begin
      if (!r.center_aligned_select) begin
        if (at_mod) begin
          next_r.cnt = `TCC_ZERO16; // [RULE18]
          ovf = 1'b1; // [RULE1]
        end else begin
          next_r.cnt = 16'(r.cnt + 16'h1);
        end
      end else if (r.down) begin
        // Count down to zero, then up again [RULE24] [RULE7]
        if (r.cnt == `TCC_ZERO16) begin
          next_r.down = 1'b0;
          next_r.cnt = 16'h0001;
        end else begin
          next_r.cnt = 16'(r.cnt - 16'h1);
        end
      end else if (at_mod) begin
        next_r.down = 1'b1; // [RULE18]
        next_r.cnt = 16'(r.cnt - 16'h1);
        ovf = 1'b1; // [RULE2]
      end else begin
        next_r.cnt = 16'(r.cnt + 16'h1);
      end
    end
    if (!r.center_aligned_select) begin
      next_r.down = 1'b0;
    end
    // Half written modulo inhibits the flag [RULE19]
    if (r.mod_half) begin
      ovf = 1'b0;
    end
    // Bus data phase
    wr_sc = (r.bus.ph == TCC_BUS_DATA) && r.bus.wr && is_reg(r.bus.addr, `TCC_ADDR_SC);
    wr_cnt = (r.bus.ph == TCC_BUS_DATA) && r.bus.wr &&
             (is_reg(r.bus.addr, `TCC_ADDR_CNTH) || is_reg(r.bus.addr, `TCC_ADDR_CNTL));
    wr_modh = (r.bus.ph == TCC_BUS_DATA) && r.bus.wr && is_reg(r.bus.addr, `TCC_ADDR_MODH);
    wr_modl = (r.bus.ph == TCC_BUS_DATA) && r.bus.wr && is_reg(r.bus.addr, `TCC_ADDR_MODL);
    rd_sc = (r.bus.ph == TCC_BUS_DATA) && !r.bus.wr && is_reg(r.bus.addr, `TCC_ADDR_SC);
    rd_cnt = (r.bus.ph == TCC_BUS_DATA) && !r.bus.wr &&
             (is_reg(r.bus.addr, `TCC_ADDR_CNTH) || is_reg(r.bus.addr, `TCC_ADDR_CNTL));
    if (wr_sc) begin
      next_r.overflow_irq_enable = wd[`TCC_BIT_OVERFLOW_IRQ_ENABLE]; // [RULE6]
      next_r.center_aligned_select = wd[`TCC_BIT_CENTER_ALIGNED_SELECT]; // [RULE7]
      next_r.clks = wd[4:3]; // [RULE8]
      next_r.ps = wd[2:0]; // [RULE10]
      // Clear only when armed by an earlier read; writing one keeps the flag, and every status write disarms [RULE3] [RULE5]
      if (r.clr_armed && !wd[`TCC_BIT_TOF]) begin
        next_r.overflow_flag = 1'b0;
      end
      next_r.clr_armed = 1'b0;
    end
    if (rd_sc && r.overflow_flag) begin
      next_r.clr_armed = 1'b1; // [RULE3]
    end
    // New overflow wins over clear and disarms the sequence [RULE4]
    if (ovf) begin
      next_r.overflow_flag = 1'b1;
      next_r.clr_armed = 1'b0;
    end
    if (wr_cnt) begin
      next_r.cnt = `TCC_ZERO16; // [RULE16]
      next_r.down = 1'b0;
      next_r.pre_cnt = 7'h0;
    end
    // Coherent read latch, restarted by counter or status writes, held in debug [RULE13] [RULE14] [RULE17]
    if (wr_cnt || wr_sc) begin
      next_r.latched = 1'b0;
    end else if (rd_cnt && !bdm_active) begin
      next_r.latched = !r.latched;
    end
    if (wr_modh) begin
      next_r.mod_hbuf = wd;
      next_r.mod_half = !r.mod_half;
      if (r.mod_half) begin
        next_r.mod = {wd, r.mod[7:0]};
      end
    end
    if (wr_modl) begin
      next_r.mod_half = !r.mod_half;
      if (r.mod_half) begin
        next_r.mod = {r.mod_hbuf, wd};
      end else begin
        next_r.mod_hbuf = r.mod[15:8];
        next_r.mod = {r.mod[15:8], wd};
      end
    end
    if (wr_modh && r.mod_half) begin
      next_r.mod = {wd, r.mod[7:0]};
    end
    // Address phase capture
    if (hready) begin
      if (hsel && htrans[1]) begin
        next_r.bus.addr = haddr[11:0];
        next_r.bus.wr = hwrite;
        next_r.bus.ph = TCC_BUS_DATA;
      end else begin
        next_r.bus.ph = TCC_BUS_IDLE;
      end
      next_r.hrdata = 32'h0000_0000;
      if (hsel && htrans[1] && !hwrite) begin
        case (haddr[11:0])
          `TCC_ADDR_SC: next_r.hrdata = {24'h00_0000, r.overflow_flag, r.overflow_irq_enable, r.center_aligned_select, r.clks, r.ps};
          `TCC_ADDR_CNTH: next_r.hrdata = {24'h00_0000,
                                          r.latched ? r.cnt_latch[15:8] : r.cnt[15:8]};
          `TCC_ADDR_CNTL: next_r.hrdata = {24'h00_0000,
                                          r.latched ? r.cnt_latch[7:0] : r.cnt[7:0]};
          `TCC_ADDR_MODH: next_r.hrdata = {24'h00_0000, r.mod[15:8]};
          `TCC_ADDR_MODL: next_r.hrdata = {24'h00_0000, r.mod[7:0]};
          default: next_r.hrdata = 32'h0000_0000;
        endcase
        if (!r.latched && !bdm_active) begin
          next_r.cnt_latch = r.cnt; // [RULE13]
        end
      end
    end
    ovf_evt = ovf;
    next_r.irq = next_r.overflow_flag && next_r.overflow_irq_enable; // [RULE6]
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      r <= '0; // [RULE15] [RULE20] [RULE5]
    end else if (!rst_n_int) begin
      r <= '0;
      r.rst_sync <= {r.rst_sync[0], 1'b1};
    end else begin
      r <= next_r;
    end
  end

  property p_irq;
    @(posedge mclk) disable iff (!rst_n_int) (r.overflow_flag && r.overflow_irq_enable) |-> overflow_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing"); // [RULE6]

  property p_onewrite;
    @(posedge mclk) disable iff (!rst_n_int)
      (r.bus.ph == TCC_BUS_DATA && r.bus.wr && r.bus.addr == `TCC_ADDR_SC &&
       hwdata[7] && r.overflow_flag) |=> r.overflow_flag;
  endproperty
  a_onewrite: assert property (p_onewrite) else $error("flag cleared by one"); // [RULE5]

  property p_cntwr;
    @(posedge mclk) disable iff (!rst_n_int)
      (r.bus.ph == TCC_BUS_DATA && r.bus.wr && r.bus.addr == `TCC_ADDR_CNTL) |=>
      r.cnt == 16'h0000;
  endproperty
  a_cntwr: assert property (p_cntwr) else $error("counter not reset"); // [RULE16]

  property p_freeze;
    @(posedge mclk) disable iff (!rst_n_int) bdm_active |=> $stable(r.cnt) || r.cnt == 16'h0;
  endproperty
  a_freeze: assert property (p_freeze) else $error("counter moved in debug"); // [RULE17]

  property p_off;
    @(posedge mclk) disable iff (!rst_n_int) (r.clks == 2'h0 && !r.bus.wr) |=> $stable(r.cnt);
  endproperty
  a_off: assert property (p_off) else $error("counter ran with clock off"); // [RULE8]

  property p_wrap;
    @(posedge mclk) disable iff (!rst_n_int)
      (!r.center_aligned_select && $past(r.cnt) != 16'h0 && r.cnt == 16'h0 && !r.mod_half &&
       !$past(r.bus.wr)) |-> r.overflow_flag;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap without flag"); // [RULE1]

  property p_half;
    @(posedge mclk) disable iff (!rst_n_int) (r.mod_half && !r.overflow_flag) |=> !r.overflow_flag;
  endproperty
  a_half: assert property (p_half) else $error("flag during modulo write"); // [RULE19]

  property p_sc;
    @(posedge mclk) disable iff (!rst_n_int)
      (r.bus.ph == TCC_BUS_DATA && r.bus.wr && r.bus.addr == `TCC_ADDR_SC) |=>
      !r.latched && !r.clr_armed;
  endproperty
  a_sc: assert property (p_sc) else $error("latch not restarted"); // [RULE14]

  // Steps of the flag clear; an overflow in between must win
  sequence s_sc_read_set;
    sc_rd_phase && r.overflow_flag;
  endsequence

  sequence s_clear_request;
    sc_clear_wr && r.clr_armed && !ovf_evt;
  endsequence

  sequence s_new_overflow;
    ovf_evt;
  endsequence

  property p_arm;
    @(posedge mclk) disable iff (!rst_n_int)
      (s_sc_read_set ##0 !ovf_evt) |=> r.clr_armed;
  endproperty
  a_arm: assert property (p_arm) else $error("clear not armed by read"); // [RULE3]

  property p_arm_only;
    @(posedge mclk) disable iff (!rst_n_int)
      $rose(r.clr_armed) |-> $past(sc_rd_phase) && $past(r.overflow_flag);
  endproperty
  a_arm_only: assert property (p_arm_only) else $error("clear armed without read"); // [RULE3]

  property p_clear;
    @(posedge mclk) disable iff (!rst_n_int) s_clear_request |=> !r.overflow_flag;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared"); // [RULE3]

  property p_race;
    @(posedge mclk) disable iff (!rst_n_int) s_new_overflow |=> r.overflow_flag && !r.clr_armed;
  endproperty
  a_race: assert property (p_race) else $error("overflow lost in clear"); // [RULE4]

  property p_fall;
    @(posedge mclk) disable iff (!rst_n_int)
      $fell(r.overflow_flag) |-> $past(sc_clear_wr) && $past(r.clr_armed);
  endproperty
  a_fall: assert property (p_fall) else $error("flag fell without clear"); // [RULE3] [RULE5]

  // Either counter byte written restarts both the count and the read latch
  property p_cnth;
    @(posedge mclk) disable iff (!rst_n_int)
      cnt_wr_phase |=> (r.cnt == `TCC_ZERO16) && !r.latched;
  endproperty
  a_cnth: assert property (p_cnth) else $error("counter write ignored"); // [RULE16] [RULE14]

  property p_latch;
    @(posedge mclk) disable iff (!rst_n_int) r.latched |=> $stable(r.cnt_latch);
  endproperty
  a_latch: assert property (p_latch) else $error("held count changed"); // [RULE13]

  property p_frz_latch;
    @(posedge mclk) disable iff (!rst_n_int)
      (bdm_active && !sc_wr_phase && !cnt_wr_phase) |=> $stable(r.latched);
  endproperty
  a_frz_latch: assert property (p_frz_latch) else $error("latch moved in debug"); // [RULE17]

  property p_turn;
    @(posedge mclk) disable iff (!rst_n_int)
      ($rose(r.down) && !$past(r.mod_half)) |-> r.overflow_flag;
  endproperty
  a_turn: assert property (p_turn) else $error("no flag at turn"); // [RULE2]

  // Down half: hold or one step lower, never a jump
  property p_down;
    @(posedge mclk) disable iff (!rst_n_int)
      (r.center_aligned_select && r.down && r.cnt != `TCC_ZERO16 && !cnt_wr_phase && !sc_wr_phase) |=>
      (r.cnt == $past(r.cnt)) || (r.cnt == 16'($past(r.cnt) - 16'h1));
  endproperty
  a_down: assert property (p_down) else $error("bad down step"); // [RULE24]

  property p_up;
    @(posedge mclk) disable iff (!rst_n_int)
      (!r.center_aligned_select && !cnt_wr_phase && !sc_wr_phase) |=>
      (r.cnt == $past(r.cnt)) || (r.cnt == 16'($past(r.cnt) + 16'h1)) ||
      (r.cnt == `TCC_ZERO16);
  endproperty
  a_up: assert property (p_up) else $error("bad up step"); // [RULE18]

  property p_mod;
    @(posedge mclk) disable iff (!rst_n_int) $changed(r.mod) |-> $past(r.bus.wr);
  endproperty
  a_mod: assert property (p_mod) else $error("modulo changed without write"); // [RULE19]
endmodule

// ==== include/tcc_params.svh ====
// Constants for the timer counter control core
// Overview of operation
// (RULE1) Up mode: overflow flag sets when counter wraps to 0x0000 after modulo.
// (RULE2) Center mode: flag sets at step down from modulo value.
// (RULE3) Flag clears by status read while set, then writing zero to bit 7.
// (RULE4) New overflow between read and write restarts clear; flag stays set.
// (RULE5) Writing one to flag does nothing; reset clears flag.
// (RULE6) Interrupt request when flag and enable bit 6 both set; reset clears enable.
// (RULE7) Bit 5 selects center-aligned up/down counting; reset clears it.
// (RULE8) Bits 4:3 pick clock: off, bus, fixed system, external pin.
// (RULE9) External and fixed clocks are synchronised to the bus clock.
// (RULE10) Bits 2:0 divide selected clock by two to the field value.
// (RULE11) Prescaler follows source selection and synchronisation.
// (RULE12) External clock must stay at or below a quarter of bus clock.
// (RULE13) Reading either counter byte latches both until other byte is read; here the next counter read of either byte releases it.
// (RULE14) Latch restarts on reset, counter byte write, or status write.
// (RULE15) Reset clears the counter.
// (RULE16) Any counter byte write resets counter; reads never disturb counting.
// (RULE17) Debug mode freezes counter and read latch state.
// (RULE18) At modulo: restart from zero, or count down in center mode.
// (RULE19) Writing one modulo byte inhibits overflow until other byte written; here the next write of either modulo byte ends it.
// (RULE20) Reset loads modulo with 0x0000, free-running.
// (RULE21) Modulo 0x0000 or 0xFFFF gives free-running 16-bit counter.
// (RULE22) Software should write modulo soon after overflow or reset counter first.
// (RULE23) Shared external clock pin: software sets channel edge select to 0:0.
// (RULE24) Center mode counts down to 0x0000 then up, one step per tick.
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH
`define TCC_ADDR_SC 12'h000
`define TCC_ADDR_CNTH 12'h004
`define TCC_ADDR_CNTL 12'h008
`define TCC_ADDR_MODH 12'h00C
`define TCC_ADDR_MODL 12'h010
`define TCC_BIT_TOF 7
`define TCC_BIT_OVERFLOW_IRQ_ENABLE 6
`define TCC_BIT_CENTER_ALIGNED_SELECT 5
`define TCC_CLK_OFF 2'h0
`define TCC_CLK_BUS 2'h1
`define TCC_CLK_FIX 2'h2
`define TCC_CLK_EXT 2'h3
`define TCC_ZERO16 16'h0000
`define TCC_ALL16 16'hFFFF
`endif

// ==== include/tcc_pkg.sv ====
// Types for the timer counter control core
package tcc_pkg;
  typedef enum logic [1:0] {
    TCC_BUS_IDLE = 2'b00,
    TCC_BUS_DATA = 2'b01
  } tcc_bus_e;
  typedef struct packed {
    logic [11:0] addr;
    logic wr;
    tcc_bus_e ph;
  } tcc_ahb_s;
  typedef struct packed {
    logic [1:0] rst_sync;
    logic [1:0] ext_sync;
    logic [1:0] fix_sync;
    logic ext_prev;
    logic fix_prev;
    logic [6:0] pre_cnt;
    logic [15:0] cnt;
    logic down;
    logic [15:0] mod;
    logic [7:0] mod_hbuf;
    logic mod_half;
    logic overflow_flag;
    logic overflow_irq_enable;
    logic center_aligned_select;
    logic [1:0] clks;
    logic [2:0] ps;
    logic clr_armed;
    logic [15:0] cnt_latch;
    logic latched;
    tcc_ahb_s bus;
    logic [31:0] hrdata;
    logic irq;
  } tcc_state_s;
endpackage

// ==== sim/tcc_core_tb.sv ====
// Self-checking testbench for the timer counter control core
`timescale 1ns/1ns
`include "tcc_params.svh"
module tcc_core_tb;
  import tcc_pkg::*;
  logic mclk, rstn, hsel, hwrite, hready, hresp;
  logic ext_clk_pin, fixed_clk_in, bdm_active, overflow_irq;
  logic [31:0] haddr, hwdata, hrdata, rd, held;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int num_errors, checks;

  // Zero-wait slave, so its ready drives the bus ready directly
  tcc_core DUT (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .ext_clk_pin(ext_clk_pin),
    .fixed_clk_in(fixed_clk_in), .bdm_active(bdm_active), .overflow_irq(overflow_irq));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h0_0000, a};
    hwrite <= w;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= {24'h00_0000, d};
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask

  task automatic rchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    chk(name, exp, rd);
  endtask

  task automatic poll_flag(input string name);
    for (int i = 0; i < 60; i++) begin
      bus(1'b0, `TCC_ADDR_SC, 8'h00);
      if (rd[7] === 1'b1) break;
    end
    chk(name, 32'h0000_0001, {31'h0, rd[7]});
  endtask

  task automatic t_reset();
    rchk("sc_reset", `TCC_ADDR_SC, 32'h0000_0000);
    rchk("modh_reset", `TCC_ADDR_MODH, 32'h0000_0000);
    rchk("modl_reset", `TCC_ADDR_MODL, 32'h0000_0000);
    rchk("cntl_reset", `TCC_ADDR_CNTL, 32'h0000_0000);
    rchk("cnth_reset", `TCC_ADDR_CNTH, 32'h0000_0000);
    rchk("unmapped", 12'h020, 32'h0000_0000);
    chk("irq_reset", 32'h0, {31'h0, overflow_irq});
    chk("hresp_okay", 32'h0, {31'h0, hresp});
    $display("test reset done");
  endtask

  task automatic t_overflow();
    bus(1'b1, `TCC_ADDR_MODH, 8'h00);
    bus(1'b1, `TCC_ADDR_MODL, 8'h05);
    bus(1'b1, `TCC_ADDR_SC, 8'h48);
    poll_flag("flag_up");
    @(posedge mclk);
    chk("irq_set", 32'h1, {31'h0, overflow_irq});
    // Writing one must not clear, and the read before it arms the clear
    bus(1'b1, `TCC_ADDR_SC, 8'hC0);
    rchk("flag_w1", `TCC_ADDR_SC, 32'h0000_00C0);
    bus(1'b1, `TCC_ADDR_SC, 8'h40);
    rchk("flag_clr", `TCC_ADDR_SC, 32'h0000_0040);
    chk("irq_clr", 32'h0, {31'h0, overflow_irq});
    $display("test overflow done");
  endtask

  task automatic t_clear_race();
    bus(1'b1, `TCC_ADDR_SC, 8'h48);
    poll_flag("flag_race");
    // Period is six cycles, so a new overflow lands before the write
    repeat (12) @(posedge mclk);
    // Zero also stops the clock, so no later overflow can mask the result
    bus(1'b1, `TCC_ADDR_SC, 8'h00);
    rchk("flag_kept", `TCC_ADDR_SC, 32'h0000_0080);
    bus(1'b1, `TCC_ADDR_SC, 8'h00);
    rchk("flag_clr2", `TCC_ADDR_SC, 32'h0000_0000);
    $display("test clear race done");
  endtask

  task automatic t_counter();
    bus(1'b1, `TCC_ADDR_MODH, 8'h00);
    bus(1'b1, `TCC_ADDR_MODL, 8'h00);
    bus(1'b1, `TCC_ADDR_CNTH, 8'hAB);
    rchk("cnt_wr_low", `TCC_ADDR_CNTL, 32'h0000_0000);
    rchk("cnt_wr_high", `TCC_ADDR_CNTH, 32'h0000_0000);
    bus(1'b1, `TCC_ADDR_SC, 8'h08);
    bus(1'b1, `TCC_ADDR_CNTL, 8'h55);
    bus(1'b0, `TCC_ADDR_CNTL, 8'h00);
    // Live high byte passes 1 during the wait; the held copy must not
    repeat (300) @(posedge mclk);
    rchk("cnt_coherent", `TCC_ADDR_CNTH, 32'h0000_0000);
    // Hold a copy with high byte 1, then let the live count pass 0x200
    bus(1'b0, `TCC_ADDR_CNTL, 8'h00);
    repeat (250) @(posedge mclk);
    bus(1'b1, `TCC_ADDR_SC, 8'h08);
    rchk("cnt_restart", `TCC_ADDR_CNTH, 32'h0000_0002);
    bus(1'b0, `TCC_ADDR_CNTL, 8'h00);
    $display("test counter done");
  endtask

  task automatic t_freeze();
    bdm_active <= 1'b1;
    repeat (2) @(posedge mclk);
    bus(1'b0, `TCC_ADDR_CNTL, 8'h00);
    held = rd;
    repeat (20) @(posedge mclk);
    bus(1'b0, `TCC_ADDR_CNTH, 8'h00);
    rchk("cnt_frozen", `TCC_ADDR_CNTL, held);
    bdm_active <= 1'b0;
    $display("test freeze done");
  endtask

  task automatic t_prescale();
    bus(1'b1, `TCC_ADDR_SC, 8'h0F);
    bus(1'b1, `TCC_ADDR_CNTH, 8'h00);
    // Ticks land 128 and 256 cycles after the counter write
    repeat (300) @(posedge mclk);
    rchk("ps128_low", `TCC_ADDR_CNTL, 32'h0000_0002);
    bus(1'b0, `TCC_ADDR_CNTH, 8'h00);
    $display("test prescale done");
  endtask

  task automatic t_center();
    bus(1'b1, `TCC_ADDR_CNTH, 8'h00);
    bus(1'b1, `TCC_ADDR_MODH, 8'h00);
    bus(1'b1, `TCC_ADDR_MODL, 8'h04);
    bus(1'b1, `TCC_ADDR_SC, 8'h28);
    poll_flag("flag_center");
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, `TCC_ADDR_CNTL, 8'h00);
      chk("cnt_in_range", 32'h1, {31'h0, rd <= 32'h0000_0004});
      bus(1'b0, `TCC_ADDR_CNTH, 8'h00);
    end
    $display("test center done");
  endtask

  task automatic t_ext_clock();
    // Pin is not shared with a channel here, so no channel setup
    bus(1'b1, `TCC_ADDR_MODH, 8'h00);
    bus(1'b1, `TCC_ADDR_MODL, 8'h00);
    bus(1'b1, `TCC_ADDR_SC, 8'h18);
    bus(1'b1, `TCC_ADDR_CNTH, 8'h00);
    repeat (20) begin
      repeat (2) @(posedge mclk);
      ext_clk_pin <= ~ext_clk_pin;
    end
    repeat (4) @(posedge mclk);
    rchk("ext_edges", `TCC_ADDR_CNTL, 32'h0000_000A);
    bus(1'b0, `TCC_ADDR_CNTH, 8'h00);
    bus(1'b1, `TCC_ADDR_SC, 8'h11);
    bus(1'b1, `TCC_ADDR_CNTH, 8'h00);
    repeat (24) begin
      repeat (2) @(posedge mclk);
      fixed_clk_in <= ~fixed_clk_in;
    end
    repeat (4) @(posedge mclk);
    rchk("fix_div2", `TCC_ADDR_CNTL, 32'h0000_0006);
    bus(1'b0, `TCC_ADDR_CNTH, 8'h00);
    $display("test clock sources done");
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #(40 * 20000);
    num_errors++;
    stop_test();
  end

  initial begin
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    ext_clk_pin = 1'b0;
    fixed_clk_in = 1'b0;
    bdm_active = 1'b0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    // Internal reset release takes two edges before the first request
    repeat (4) @(posedge mclk);
    t_reset();
    t_overflow();
    t_clear_race();
    t_counter();
    t_freeze();
    t_prescale();
    t_center();
    t_ext_clock();
    stop_test();
  end
endmodule
